/* File: dv/cycle_done_chk.sv */
// assertions on the ports of the cycle completion block
// assumes bind onto cycle_done_ctrl; one clock, async active-low reset
`timescale 1ns/1ns
module cycle_done_chk
  import cycle_done_pkg::*;
#(
  parameter int unsigned SELFTEST_LEN = SELFTEST_CYCLES
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // pins and core request
  input wire logic        cycle_done_n,
  input wire logic        bus_guarantee_n,
  input wire logic        write_window_end_n,
  input wire logic        snoop_window_end_n,
  input wire logic        cycle_req,
  input wire cycle_kind_t cycle_req_kind,
  input wire logic        cycle_req_write,
  input wire logic        cycle_req_locked,
  input wire logic        cycle_req_way,
  input wire logic        cpu_split_cycle,
  // block outputs
  input wire logic        cycle_addr_strobe_n,
  input wire logic        snoop_addr_strobe_n,
  input wire logic        latched_split_cycle,
  input wire logic        write_not_read,
  input wire logic        way_indicator,
  input wire logic        cycle_req_ready,
  input wire logic        cycle_retired,
  input wire logic        buffer_commit,
  input wire logic        buffer_discard,
  input wire logic        grant_seen,
  input wire logic        next_cycle_seen,
  input wire logic        write_window_seen,
  input wire logic        snoop_window_open,
  input wire logic        self_test_request,
  input wire logic [1:0]  outstanding
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic       acc;
  logic [7:0] cnt_ff;
  assign acc = cycle_req && cycle_req_ready;

  // edges since release, saturating so it never wraps into the window
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff != 8'hFF) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  a_issue_strobe: assert property (
    acc |=> !cycle_req_ready && snoop_addr_strobe_n != cycle_addr_strobe_n
    && cycle_addr_strobe_n == ($past(cycle_req_kind) == KIND_SNOOP_WB)) else $error("strobe not issued");
  a_rw_load: assert property (
    acc |=> write_not_read == $past(cycle_req_write)) else $error("write flag wrong");
  a_way_load: assert property (
    acc |=> way_indicator == ($past(cycle_req_way) && ($past(cycle_req_kind) != KIND_CPU
    || $past(cycle_req_write)))) else $error("way wrong");
  a_split_load: assert property (
    acc |=> latched_split_cycle == ($past(cycle_req_locked) && $past(cpu_split_cycle)
    && !($past(cycle_req_kind) inside {KIND_ALLOCATE, KIND_WRITEBACK, KIND_SNOOP_WB}))) else $error("split wrong");
  a_attr_hold: assert property (
    !$past(acc) |-> $stable(write_not_read) && $stable(way_indicator)
    && $stable(latched_split_cycle)) else $error("attributes moved");
  a_pipe_depth: assert property (
    outstanding != 2'd3 && (outstanding != 2'd2 || !cycle_req_ready)) else $error("too deep");
  a_done_retire: assert property (
    $fell(cycle_done_n) && outstanding != 2'd0 && cnt_ff > SELFTEST_LEN |-> ##4 cycle_retired)
    else $error("done not taken");
  a_retire_count: assert property (
    cycle_retired |-> $past(outstanding) != 2'd0
    && outstanding == $past(outstanding) - 2'd1 + {1'b0, $past(acc)}) else $error("bad retire");
  a_buffer_pair: assert property (
    (buffer_commit || buffer_discard) == cycle_retired && !(buffer_commit && buffer_discard))
    else $error("buffer pulse wrong");
  a_grant_next: assert property (
    $fell(bus_guarantee_n) && outstanding != 2'd0 |-> ##4 grant_seen) else $error("grant missed");
  a_write_window_end_n_seen: assert property (
    $fell(write_window_end_n) && outstanding != 2'd0 |-> ##4 write_window_seen) else $error("write window missed");
  a_cna_reopens: assert property (
    next_cycle_seen |-> cycle_req_ready && outstanding == 2'd1) else $error("next cycle request not taken");
  a_window_stays: assert property (
    snoop_window_open && snoop_window_end_n && $past(snoop_window_end_n) && $past(snoop_window_end_n, 2)
    && $past(snoop_window_end_n, 3) && $past(snoop_window_end_n, 4) |=> snoop_window_open)
    else $error("window closed");
  a_selftest_sticky: assert property (
    self_test_request |=> self_test_request) else $error("self test dropped");
  a_no_early_retire: assert property (
    cnt_ff < SELFTEST_LEN |-> !cycle_retired) else $error("retire in self test");

  c_two_deep: cover property (outstanding == 2'd2);
  c_commit: cover property (buffer_commit);
  c_snoop: cover property (!snoop_addr_strobe_n);
endmodule : cycle_done_chk

/* File: dv/mem_bus_model.sv */
// memory bus controller model driving the progress strobes
// assumes cycles are served strictly in order, one at a time
`timescale 1ns/1ns
module mem_bus_model
  import cycle_done_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // strobes from the block
  input  wire logic cycle_addr_strobe_n,
  input  wire logic snoop_addr_strobe_n,
  // scenario controls
  input  wire logic pipe_en,
  input  wire logic stray,
  input  wire logic st_hold,
  input  wire logic [31:0] lag,
  // progress strobes, idle high as with pull-ups
  output logic      cycle_done_n,
  output logic      bus_guarantee_n,
  output logic      write_window_end_n,
  output logic      snoop_window_end_n,
  output logic      cpu_burst_ready_n,
  output logic      next_cycle_request_n,
  output logic      mem_cycle_end_n,
  output logic      mem_buffer_ready_n,
  output logic      data_transfer_start_n
);
  int   issued;
  int   served;
  logic done_ff;

  // self-test request shares the done pin
  assign cycle_done_n = done_ff & ~st_hold;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      issued <= 0;
    end else if (!cycle_addr_strobe_n || !snoop_addr_strobe_n) begin
      issued <= issued + 1;
    end
  end

  initial begin
    {done_ff, bus_guarantee_n, write_window_end_n, snoop_window_end_n, cpu_burst_ready_n} = 5'h1F;
    {next_cycle_request_n, mem_cycle_end_n, mem_buffer_ready_n, data_transfer_start_n} = 4'hF;
    served = 0;
    forever begin
      @(posedge clk);
      if (!reset_n) begin
        served = 0;
        data_transfer_start_n <= 1'b1;
      end else if (stray) begin
        done_ff <= 1'b0;
        @(posedge clk);
        done_ff <= 1'b1;
      end else if (issued > served) begin
        data_transfer_start_n <= 1'b0;
        repeat (lag) @(posedge clk);
        bus_guarantee_n <= 1'b0;
        next_cycle_request_n <= ~pipe_en;
        @(posedge clk);
        bus_guarantee_n <= 1'b1;
        write_window_end_n <= 1'b0;
        next_cycle_request_n <= 1'b1;
        @(posedge clk);
        {write_window_end_n, next_cycle_request_n} <= 2'h3;
        {snoop_window_end_n, cpu_burst_ready_n, mem_buffer_ready_n} <= 3'h0;
        @(posedge clk);
        {snoop_window_end_n, cpu_burst_ready_n} <= 2'h3;
        // done three clocks after grant, with end-of-cycle and last buffer ready
        {mem_cycle_end_n, done_ff} <= 2'h0;
        @(posedge clk);
        {mem_cycle_end_n, done_ff, mem_buffer_ready_n} <= 3'h7;
        served = served + 1;
      end else begin
        data_transfer_start_n <= 1'b1;
      end
    end
  end
endmodule : mem_bus_model

/* File: dv/memory_bus_cycle_completion_test.sv */
// self-checking bench for the memory-bus cycle completion block
// assumes mem_bus_model plays the far side; checker bound at the foot
`timescale 1ns/1ns
module memory_bus_cycle_completion_test
  import cycle_done_pkg::*;
;
  localparam int unsigned ST_LEN = 8;
  logic        clk, reset_n, pipe_en, stray, st_hold;
  int          lag, num_errors, tests_run;
  logic        cycle_done_n, bus_guarantee_n, write_window_end_n, snoop_window_end_n, cpu_burst_ready_n;
  logic        next_cycle_request_n, mem_cycle_end_n, mem_buffer_ready_n, data_transfer_start_n;
  logic        cycle_req, cycle_req_write, cycle_req_locked, cycle_req_way, cpu_split_cycle;
  cycle_kind_t cycle_req_kind;
  logic        cycle_addr_strobe_n, snoop_addr_strobe_n, latched_split_cycle, write_not_read, way_indicator;
  logic        cycle_req_ready, cycle_retired, buffer_commit, buffer_discard, buffer_fill;
  logic        next_cycle_seen, grant_seen, write_window_seen, snoop_window_open, self_test_request;
  logic [1:0]  outstanding;
  cycle_kind_t kinds [7] = '{KIND_CPU, KIND_CPU, KIND_LINEFILL, KIND_ALLOCATE, KIND_WRITEBACK, KIND_SNOOP_WB, KIND_CPU};
  // write, locked, way, split per entry
  logic [3:0]  flags [7] = '{4'h7, 4'hF, 4'h7, 4'h5, 4'hB, 4'h9, 4'h3};

  cycle_done_ctrl #(.SELFTEST_LEN(ST_LEN)) u_dut (.*);
  mem_bus_model u_mbc (.*);

  always #50 clk = ~clk;

  task automatic chk(string what, logic [1:0] exp, logic [1:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic issue(cycle_kind_t k, logic [3:0] f);
    int n;
    n = 0;
    while (cycle_req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("ready", 1'b1, cycle_req_ready);
    @(posedge clk);
    cycle_req <= 1'b1;
    cycle_req_kind <= k;
    {cycle_req_write, cycle_req_locked, cycle_req_way, cpu_split_cycle} <= f;
    @(posedge clk);
    cycle_req <= 1'b0;
    @(negedge clk);
    chk("cycle strobe", k == KIND_SNOOP_WB, cycle_addr_strobe_n);
    chk("snoop strobe", k != KIND_SNOOP_WB, snoop_addr_strobe_n);
    chk("write flag", f[3], write_not_read);
    chk("way", f[1] && (k != KIND_CPU || f[3]), way_indicator);
    chk("split", f[2] && f[0] && !(k inside {KIND_ALLOCATE, KIND_WRITEBACK, KIND_SNOOP_WB}), latched_split_cycle);
  endtask : issue

  task automatic retire(logic cm, logic wr, logic [1:0] out);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cycle_retired !== 1'b1 && n < 100);
    chk("retired", 1'b1, cycle_retired);
    chk("commit", cm, buffer_commit);
    chk("discard", !cm, buffer_discard);
    if (cm) chk("fill", 1'b1, buffer_fill);
    chk("write hold", wr, write_not_read);
    chk("outstanding", out, outstanding);
    chk("ready", out == 2'd0, cycle_req_ready);
  endtask : retire

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    {clk, reset_n, pipe_en, stray, st_hold, cycle_req} = 6'h00;
    {cycle_req_write, cycle_req_locked, cycle_req_way, cpu_split_cycle} = 4'h0;
    cycle_req_kind = KIND_CPU;
    {lag, num_errors, tests_run} = {32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    // wait out the self-test window before any traffic
    repeat (12) @(negedge clk);
    chk("idle strobes", 2'h3, {cycle_addr_strobe_n, snoop_addr_strobe_n});
    chk("idle outstanding", 2'd0, outstanding);
    chk("no self test", 1'b0, self_test_request);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      issue(kinds[i], flags[i]);
      retire(!flags[i][3] && (kinds[i] == KIND_LINEFILL || kinds[i] == KIND_ALLOCATE), flags[i][3], 2'd0);
    end
    $display("test kinds done");
    @(posedge clk);
    pipe_en <= 1'b1;
    issue(KIND_LINEFILL, 4'h7);
    issue(KIND_WRITEBACK, 4'hB);
    chk("two deep", 2'd2, outstanding);
    chk("no third", 1'b0, cycle_req_ready);
    @(posedge clk);
    pipe_en <= 1'b0;
    retire(1'b1, 1'b1, 2'd1);
    retire(1'b0, 1'b1, 2'd0);
    $display("test pipeline done");
    @(posedge clk);
    pipe_en <= 1'b1;
    issue(KIND_SNOOP_WB, 4'h9);
    repeat (6) begin
      @(negedge clk);
      chk("snoop no pipe", 1'b0, cycle_req_ready);
    end
    retire(1'b0, 1'b1, 2'd0);
    @(posedge clk);
    pipe_en <= 1'b0;
    stray <= 1'b1;
    @(posedge clk);
    stray <= 1'b0;
    repeat (8) begin
      @(negedge clk);
      chk("stray done", 1'b0, cycle_retired);
    end
    chk("stray outstanding", 2'd0, outstanding);
    $display("test stray done");
    @(posedge clk);
    lag <= 7;
    issue(KIND_CPU, 4'hF);
    retire(1'b0, 1'b1, 2'd0);
    $display("test slow done");
    @(posedge clk);
    reset_n <= 1'b0;
    st_hold <= 1'b1;
    lag <= 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    st_hold <= 1'b0;
    repeat (10) @(negedge clk);
    chk("self test", 1'b1, self_test_request);
    chk("self test outstanding", 2'd0, outstanding);
    issue(KIND_LINEFILL, 4'h7);
    retire(1'b1, 1'b0, 2'd0);
    $display("test self test done");
    wrap_up;
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("[ERR] watchdog expected finish seen hang");
    wrap_up;
  end
endmodule : memory_bus_cycle_completion_test

bind cycle_done_ctrl cycle_done_chk #(.SELFTEST_LEN(SELFTEST_LEN)) u_chk (.*);

/* File: hdl/cycle_done_ctrl.sv */
// memory-bus cycle completion: issues cycles, tracks up to two outstanding,
// retires them on the cycle-done strobe and holds the cycle attributes
// assumes the cache core raises one request at a time and the external
// memory bus controller keeps its own ordering of progress strobes
`timescale 1ns/1ns

module cycle_done_ctrl
  import cycle_done_pkg::*;
#(
  parameter int unsigned SELFTEST_LEN = SELFTEST_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // memory bus strobes from the external controller
  input  wire logic        cycle_done_n,
  input  wire logic        bus_guarantee_n,
  input  wire logic        write_window_end_n,
  input  wire logic        snoop_window_end_n,
  input  wire logic        cpu_burst_ready_n,
  input  wire logic        next_cycle_request_n,
  input  wire logic        mem_cycle_end_n,
  input  wire logic        mem_buffer_ready_n,
  // cycle request from the cache core, data_transfer_start_n from the bus controller
  input  wire logic        cycle_req,
  input  wire cycle_kind_t cycle_req_kind,
  input  wire logic        cycle_req_write,
  input  wire logic        cycle_req_locked,
  input  wire logic        cycle_req_way,
  input  wire logic        cpu_split_cycle,
  input  wire logic        data_transfer_start_n,
  // cycle strobes and attributes to the memory bus
  output logic             cycle_addr_strobe_n,
  output logic             snoop_addr_strobe_n,
  output logic             latched_split_cycle,
  output logic             write_not_read,
  output logic             way_indicator,
  // status back to the cache core
  output logic             cycle_req_ready,
  output logic             cycle_retired,
  output logic             buffer_commit,
  output logic             buffer_discard,
  output logic             buffer_fill,
  output logic             next_cycle_seen,
  output logic             grant_seen,
  output logic             write_window_seen,
  output logic             snoop_window_open,
  output logic             self_test_request,
  output logic [1:0]       outstanding
);

  initial begin
    if (SELFTEST_LEN < 1 || SELFTEST_LEN > 65535) $error("SELFTEST_LEN out of range");
  end

  // pin sampling
  logic [PIN_COUNT-1:0] pins_raw;
  logic [PIN_COUNT-1:0] pins_ff;

  always_comb begin
    pins_raw            = PIN_IDLE;
    pins_raw[PIN_DONE]  = cycle_done_n;
    pins_raw[PIN_GRANT] = bus_guarantee_n;
    pins_raw[PIN_WRITE_WINDOW_END_N] = write_window_end_n;
    pins_raw[PIN_SNOOP_WINDOW_END_N] = snoop_window_end_n;
    pins_raw[PIN_CPU_BURST_READY_N]  = cpu_burst_ready_n;
    pins_raw[PIN_CNA]   = next_cycle_request_n;
    pins_raw[PIN_MEM_CYCLE_END_N]  = mem_cycle_end_n;
    pins_raw[PIN_MEM_BUFFER_READY_N] = mem_buffer_ready_n;
  end

  pin_sampler #(
    .WIDTH    (PIN_COUNT),
    .IDLE_VAL (PIN_IDLE)
  ) u_pin_sampler (
    .clk      (clk),
    .reset_n  (reset_n),
    .pins_raw (pins_raw),
    .pins_ff  (pins_ff)
  );

  logic done_pin;
  logic grant_now;
  logic write_window_end_n_now;
  logic snoop_window_end_n_now;
  logic cna_now;
  logic mem_buffer_ready_n_now;

  assign done_pin  = ~pins_ff[PIN_DONE];
  assign grant_now = ~pins_ff[PIN_GRANT];
  assign write_window_end_n_now = ~pins_ff[PIN_WRITE_WINDOW_END_N];
  assign snoop_window_end_n_now = ~pins_ff[PIN_SNOOP_WINDOW_END_N];
  assign cna_now   = ~pins_ff[PIN_CNA];
  assign mem_buffer_ready_n_now = ~pins_ff[PIN_MEM_BUFFER_READY_N];

  // cycle attribute decode: kind_is_own for issue, kind_fills_array for retire
  function automatic logic kind_is_own(input cycle_kind_t kind);
    return (kind == KIND_WRITEBACK) || (kind == KIND_SNOOP_WB) || (kind == KIND_ALLOCATE);
  endfunction : kind_is_own

  function automatic logic kind_fills_array(input cycle_kind_t kind, input logic wr);
    return !wr && ((kind == KIND_LINEFILL) || (kind == KIND_ALLOCATE));
  endfunction : kind_fills_array

  // self-test window: the shared pin means self-test only just after reset
  logic [15:0] selftest_cnt_ff;
  logic        selftest_phase_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selftest_cnt_ff   <= 16'h0000;
      selftest_phase_ff <= 1'b1;
    end else if (selftest_phase_ff) begin
      selftest_cnt_ff <= selftest_cnt_ff + 16'h0001;
      if (selftest_cnt_ff == 16'(SELFTEST_LEN - 1)) begin
        selftest_phase_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      self_test_request <= ATTR_RESET;
    end else if (selftest_phase_ff && done_pin) begin
      self_test_request <= 1'b1;
    end
  end

  // sampled every edge; only the self-test phase claims the pin instead
  logic done_now;
  assign done_now = done_pin && !selftest_phase_ff;

  // outstanding-cycle queue
  occupancy_t  occ_ff;
  occupancy_t  nxt_occ;
  cycle_kind_t head_kind_ff;
  cycle_kind_t tail_kind_ff;
  logic        head_write_ff;
  logic        tail_write_ff;
  logic        retire;
  logic        accept;

  assign retire = done_now && (occ_ff != OCC_IDLE);
  assign accept = cycle_req && cycle_req_ready;

  always_comb begin
    nxt_occ = occ_ff;
    unique case (occ_ff)
      OCC_IDLE: begin
        if (accept) nxt_occ = OCC_ONE;
      end
      OCC_ONE: begin
        if (accept && !retire) nxt_occ = OCC_TWO;
        else if (!accept && retire) nxt_occ = OCC_IDLE;
      end
      OCC_TWO: begin
        if (retire) nxt_occ = OCC_ONE;
      end
      default: nxt_occ = OCC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      occ_ff <= OCC_IDLE;
    end else begin
      occ_ff <= nxt_occ;
    end
  end

  // head is the oldest cycle; retiring it promotes the pipelined one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      head_kind_ff  <= KIND_CPU;
      head_write_ff <= ATTR_RESET;
      tail_kind_ff  <= KIND_CPU;
      tail_write_ff <= ATTR_RESET;
    end else begin
      if (accept && (occ_ff == OCC_IDLE || (occ_ff == OCC_ONE && retire))) begin
        head_kind_ff  <= cycle_req_kind;
        head_write_ff <= cycle_req_write;
      end else if (accept) begin
        tail_kind_ff  <= cycle_req_kind;
        tail_write_ff <= cycle_req_write;
      end else if (retire && occ_ff == OCC_TWO) begin
        head_kind_ff  <= tail_kind_ff;
        head_write_ff <= tail_write_ff;
      end
    end
  end

  // progress of the head cycle; cleared on its retire so the next one starts fresh
  logic grant_ff;
  logic dts_ff;
  logic write_window_end_n_ff;
  logic cna_ff;
  logic progress_en;
  logic cna_window;
  logic cna_take;

  assign progress_en = (occ_ff != OCC_IDLE) && !retire;
  assign cna_window  = (grant_ff || grant_now) && (dts_ff || !data_transfer_start_n);
  assign cna_take    = progress_en && cna_window && cna_now && !cna_ff
                       && (occ_ff == OCC_ONE) && (head_kind_ff != KIND_SNOOP_WB);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_ff <= 1'b0;
      dts_ff   <= 1'b0;
      write_window_end_n_ff <= 1'b0;
      cna_ff   <= 1'b0;
    end else if (retire) begin
      grant_ff <= 1'b0;
      dts_ff   <= 1'b0;
      write_window_end_n_ff <= 1'b0;
      cna_ff   <= 1'b0;
    end else if (progress_en) begin
      if (grant_now) grant_ff <= 1'b1;
      if (!data_transfer_start_n) dts_ff <= 1'b1;
      if (write_window_end_n_now) write_window_end_n_ff <= 1'b1;
      if (cna_take) cna_ff <= 1'b1;
    end
  end

  // snoop window is opened by issue and closed only by its own end strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      snoop_window_open <= 1'b0;
    end else if (accept) begin
      snoop_window_open <= 1'b1;
    end else if (snoop_window_end_n_now && (occ_ff != OCC_IDLE)) begin
      snoop_window_open <= 1'b0;
    end
  end

  // request acceptance: idle, or one outstanding with next-cycle request seen
  logic nxt_ready;

  always_comb begin
    nxt_ready = 1'b0;
    unique case (nxt_occ)
      OCC_IDLE: nxt_ready = 1'b1;
      OCC_ONE:  nxt_ready = (occ_ff == OCC_ONE) && !retire && (cna_ff || cna_take) && !accept;
      OCC_TWO:  nxt_ready = 1'b0;
      default:  nxt_ready = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cycle_req_ready <= 1'b0;
    end else begin
      cycle_req_ready <= nxt_ready;
    end
  end

  // address strobes, one clock each
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cycle_addr_strobe_n <= STROBE_IDLE_N;
      snoop_addr_strobe_n <= STROBE_IDLE_N;
    end else begin
      cycle_addr_strobe_n <= !(accept && cycle_req_kind != KIND_SNOOP_WB);
      snoop_addr_strobe_n <= !(accept && cycle_req_kind == KIND_SNOOP_WB);
    end
  end

  // cycle attributes load with the strobe and hold past done or next request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latched_split_cycle <= ATTR_RESET;
      write_not_read      <= ATTR_RESET;
    end else if (accept) begin
      latched_split_cycle <= !kind_is_own(cycle_req_kind) && cycle_req_locked
                             && cpu_split_cycle;
      write_not_read      <= cycle_req_write;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      way_indicator <= ATTR_RESET;
    end else if (accept) begin
      // way matters for fills, hit writes and writebacks; others show way 0
      if (cycle_req_kind == KIND_LINEFILL || cycle_req_kind == KIND_ALLOCATE
          || cycle_req_kind == KIND_WRITEBACK || cycle_req_kind == KIND_SNOOP_WB
          || (cycle_req_write && cycle_req_locked)
          || (cycle_req_kind == KIND_CPU && cycle_req_write)) begin
        way_indicator <= cycle_req_way;
      end else begin
        way_indicator <= ATTR_RESET;
      end
    end
  end

  // buffer handling for the head cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buffer_commit  <= 1'b0;
      buffer_discard <= 1'b0;
      cycle_retired  <= 1'b0;
    end else begin
      cycle_retired  <= retire;
      buffer_commit  <= retire && kind_fills_array(head_kind_ff, head_write_ff);
      buffer_discard <= retire && !kind_fills_array(head_kind_ff, head_write_ff);
    end
  end

  // read data from memory fills the head buffer, even in the done clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buffer_fill <= 1'b0;
    end else begin
      buffer_fill <= mem_buffer_ready_n_now && (occ_ff != OCC_IDLE) && !head_write_ff;
    end
  end

  // progress pulses to the core
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      next_cycle_seen   <= 1'b0;
      grant_seen        <= 1'b0;
      write_window_seen <= 1'b0;
    end else begin
      next_cycle_seen   <= cna_take;
      grant_seen        <= progress_en && grant_now && !grant_ff;
      write_window_seen <= progress_en && write_window_end_n_now && !write_window_end_n_ff;
    end
  end

  // queue depth for the core, registered from the next occupancy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      outstanding <= 2'h0;
    end else begin
      unique case (nxt_occ)
        OCC_IDLE: outstanding <= 2'h0;
        OCC_ONE:  outstanding <= 2'h1;
        OCC_TWO:  outstanding <= 2'h2;
        default:  outstanding <= 2'h0;
      endcase
    end
  end

endmodule : cycle_done_ctrl

/* File: hdl/cycle_done_pkg.sv */
// constants and types for the memory-bus cycle completion block
// assumes a single 10 MHz clock and active-low memory-bus strobes
package cycle_done_pkg;

  // clock rate and self-test window after reset release
  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned SELFTEST_WINDOW_NS = 800;
  localparam int unsigned SELFTEST_CYCLES   =
    (SELFTEST_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // synchroniser depth and positions of the pin inputs in the sync vector
  localparam int unsigned SYNC_DEPTH = 3;
  localparam int unsigned PIN_DONE   = 0;
  localparam int unsigned PIN_GRANT  = 1;
  localparam int unsigned PIN_WRITE_WINDOW_END_N  = 2;
  localparam int unsigned PIN_SNOOP_WINDOW_END_N  = 3;
  localparam int unsigned PIN_CPU_BURST_READY_N   = 4;
  localparam int unsigned PIN_CNA    = 5;
  localparam int unsigned PIN_MEM_CYCLE_END_N   = 6;
  localparam int unsigned PIN_MEM_BUFFER_READY_N  = 7;
  localparam int unsigned PIN_COUNT  = 8;

  // idle level of every active-low pin after reset
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 8'hFF;

  // reset values of the outputs
  localparam logic STROBE_IDLE_N = 1'b1;
  localparam logic ATTR_RESET    = 1'b0;

  // kind of a memory-bus cycle requested by the cache core
  typedef enum logic [2:0] {
    KIND_CPU       = 3'h0,
    KIND_LINEFILL  = 3'h1,
    KIND_ALLOCATE  = 3'h2,
    KIND_WRITEBACK = 3'h3,
    KIND_SNOOP_WB  = 3'h4
  } cycle_kind_t;

  // occupancy of the two-deep outstanding-cycle queue
  typedef enum logic [2:0] {
    OCC_IDLE = 3'b001,
    OCC_ONE  = 3'b010,
    OCC_TWO  = 3'b100
  } occupancy_t;

endpackage : cycle_done_pkg

/* File: hdl/pin_sampler.sv */
// three-stage sampler for the memory-bus strobe pins
// assumes pins arrive from outside the clock domain and hold each level for
// at least one clock; the third stage is the level the core uses
`timescale 1ns/1ns
module pin_sampler
  import cycle_done_pkg::*;
#(
  parameter int unsigned        WIDTH    = PIN_COUNT,
  parameter logic [WIDTH-1:0]   IDLE_VAL = PIN_IDLE
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // raw pins and third-stage sampled levels
  input  wire logic [WIDTH-1:0] pins_raw,
  output logic      [WIDTH-1:0] pins_ff
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;

  initial begin
    if (WIDTH < 1) $error("pin_sampler needs at least one pin");
  end

  // first stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff   <= IDLE_VAL;
      stage2_ff <= IDLE_VAL;
      stage3_ff <= IDLE_VAL;
    end else begin
      meta_ff   <= pins_raw;
      stage2_ff <= meta_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // strobes are one clock wide: a two-stage agreement filter would swallow
  // them, so the third stage feeds the core as it stands
  assign pins_ff = stage3_ff;

endmodule : pin_sampler
